// *** core/iussr_regs.vh ***
// Register offsets, field positions and reset values of the status and sense block
`ifndef IUSSR_REGS_VH
`define IUSSR_REGS_VH
// Register byte offsets
`define IUSSR_CTRL_OFS     12'h000
`define IUSSR_EVENT_OFS    12'h004
`define IUSSR_STATUS_OFS   12'h008
`define IUSSR_SENSE_OFS    12'h00c
`define IUSSR_STATE_OFS    12'h010
// Status byte bit positions
`define IUSSR_ST_ALERT     0
`define IUSSR_ST_QUAL      1
`define IUSSR_ST_CUFREE    2
`define IUSSR_ST_BUSY      3
`define IUSSR_ST_XFER      4
`define IUSSR_ST_OPDONE    5
`define IUSSR_ST_ERR       6
`define IUSSR_ST_UNUSUAL   7
// Sense byte bit positions
`define IUSSR_SN_ILLCMD    0
`define IUSSR_SN_OPER      1
`define IUSSR_SN_PARITY    2
`define IUSSR_SN_HWFAULT   3
`define IUSSR_SN_DATAERR   4
`define IUSSR_SN_LATE      5
// CTRL register fields
`define IUSSR_CTRL_SHARED  0
`define IUSSR_CTRL_NOCUR   1
`define IUSSR_CTRL_RST     8'h00
// EVENT register fields (write one to trigger)
`define IUSSR_EV_XFEREND   0
`define IUSSR_EV_OPEND     1
`define IUSSR_EV_UNUSUAL   2
`define IUSSR_EV_SPECIAL   3
`define IUSSR_EV_RETRY     4
`define IUSSR_EV_HWFAULT   5
`define IUSSR_EV_DATAERR   6
`define IUSSR_EV_LATE      7
`define IUSSR_EV_ASYNC     8
`endif

// *** core/iussr_sync.v ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module iussr_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // Pin side
  input  wire [WIDTH-1:0] pinIn,
  // Synchronised side
  output wire [WIDTH-1:0] levelOut
);

  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;
  reg [WIDTH-1:0] stage3_ff;
  reg [WIDTH-1:0] level_ff;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      always @(posedge clk) begin
        if (sys_rst) begin
          stage1_ff[i] <= 1'b0;
          stage2_ff[i] <= 1'b0;
          stage3_ff[i] <= 1'b0;
          level_ff[i]  <= 1'b0;
        end else begin
          stage1_ff[i] <= pinIn[i];
          stage2_ff[i] <= stage1_ff[i];
          stage3_ff[i] <= stage2_ff[i];
          // Change accepted once second and third stages agree
          if (stage2_ff[i] == stage3_ff[i]) begin
            level_ff[i] <= stage3_ff[i];
          end
        end
      end
    end
  endgenerate

  assign levelOut = level_ff;

endmodule // iussr_sync

// *** core/iussr_status_sense.v ***
// Status byte and sense byte reporting logic of an I/O unit
`timescale 1ns/1ps
`include "iussr_regs.vh"
module iussr_status_sense (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Channel command side, same clock
  input  wire        selStart,
  input  wire [1:0]  cmdKind,
  input  wire        cmdParityBad,
  input  wire        cmdIllegal,
  input  wire        cmdImmediate,
  input  wire        statusAccept,
  input  wire        statusPollAllowed,
  // Device pin
  input  wire        deviceReadyPin,
  // Status toward channel
  output reg  [7:0]  statusByte,
  output reg         statusParity,
  output reg         statusValid,
  output reg         retryMarkTag,
  output reg  [7:0]  senseByte
);

  // Command kinds
  localparam [1:0] CMD_OTHER = 2'h0;
  localparam [1:0] CMD_QUERY = 2'h1;
  localparam [1:0] CMD_POLL  = 2'h2;
  localparam [1:0] CMD_IDLE  = 2'h3;

  // Operation states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_XFER = 3'b010;
  localparam [2:0] ST_DEV  = 3'b100;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  wire devReady;
  iussr_sync #(
    .WIDTH (1)
  ) uSync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pinIn    (deviceReadyPin),
    .levelOut (devReady)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0]  ctrl_ff;
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [7:0]  pend_ff;
  reg  [7:0]  nxt_pend;
  reg  [7:0]  sense_ff;
  reg  [7:0]  nxt_sense;
  reg         retryPend_ff;
  reg         nxt_retryPend;
  reg         devReadyQ_ff;
  reg  [7:0]  nxt_statusByte;
  reg         nxt_statusValid;
  reg         nxt_retryMark;

  wire        apbAccess = psel & penable;
  wire        apbWrite  = apbAccess & pwrite;
  wire        evWrite   = apbWrite & (paddr == `IUSSR_EVENT_OFS);
  wire [8:0]  ev        = evWrite ? pwdata[8:0] : 9'h000;
  wire        shared    = ctrl_ff[`IUSSR_CTRL_SHARED];
  wire        noCurrent = ctrl_ff[`IUSSR_CTRL_NOCUR];
  wire        opActive  = ~state_ff[0];
  wire        readyRise = devReady & ~devReadyQ_ff;
  wire        endPend   = pend_ff[`IUSSR_ST_XFER] | pend_ff[`IUSSR_ST_OPDONE] |
                          pend_ff[`IUSSR_ST_CUFREE] | pend_ff[`IUSSR_ST_ALERT];
  wire        anyPend   = |pend_ff;
  wire        busyNow   = opActive | anyPend;
  // Controller freed alone waits until the operation ends
  wire        freeOnly  = ~|(pend_ff & ~(8'h01 << `IUSSR_ST_CUFREE));
  wire        offerPend = anyPend & ~(opActive & freeOnly);

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Status and sense sequencing
  always @* begin
    nxt_state       = state_ff;
    nxt_pend        = pend_ff;
    nxt_sense       = sense_ff;
    nxt_retryPend   = retryPend_ff;
    nxt_statusByte  = statusByte;
    nxt_statusValid = statusValid;
    nxt_retryMark   = retryMarkTag;

    // Accepted status is gone for good
    if (statusValid && statusAccept) begin
      nxt_statusValid = 1'b0;
      nxt_retryMark   = 1'b0;
      nxt_statusByte  = 8'h00;
      if (statusByte[`IUSSR_ST_OPDONE]) begin
        nxt_state = ST_IDLE;
      end
    end

    // Device-side events, stacked until presented
    if (ev[`IUSSR_EV_XFEREND] && state_ff[1]) begin
      nxt_pend[`IUSSR_ST_XFER] = 1'b1;
      nxt_state = ST_DEV;
    end
    if (ev[`IUSSR_EV_OPEND] && opActive) begin
      if (state_ff[1]) begin
        nxt_pend[`IUSSR_ST_XFER] = 1'b1;
      end
      nxt_pend[`IUSSR_ST_OPDONE] = 1'b1;
      nxt_state = ST_DEV;
    end
    if (ev[`IUSSR_EV_SPECIAL] && opActive) begin
      nxt_pend[`IUSSR_ST_QUAL]   = 1'b1;
      nxt_pend[`IUSSR_ST_OPDONE] = 1'b1;
      nxt_state = ST_DEV;
    end
    if (ev[`IUSSR_EV_UNUSUAL] && opActive) begin
      nxt_pend[`IUSSR_ST_UNUSUAL] = 1'b1;
      if (shared && state_ff[2]) begin
        nxt_pend[`IUSSR_ST_CUFREE] = 1'b1;
      end
    end
    if (ev[`IUSSR_EV_RETRY] && opActive) begin
      nxt_pend[`IUSSR_ST_QUAL] = 1'b1;
      nxt_pend[`IUSSR_ST_XFER] = 1'b1;
      nxt_pend[`IUSSR_ST_ERR]  = 1'b1;
      nxt_retryPend = 1'b1;
      nxt_state     = ST_DEV;
    end
    if (ev[`IUSSR_EV_HWFAULT] && opActive) begin
      nxt_sense[`IUSSR_SN_HWFAULT] = 1'b1;
      nxt_pend[`IUSSR_ST_ERR] = 1'b1;
    end
    if (ev[`IUSSR_EV_DATAERR] && opActive) begin
      nxt_sense[`IUSSR_SN_DATAERR] = 1'b1;
      nxt_pend[`IUSSR_ST_ERR] = 1'b1;
    end
    if (ev[`IUSSR_EV_LATE] && opActive) begin
      nxt_sense[`IUSSR_SN_LATE] = 1'b1;
      nxt_pend[`IUSSR_ST_ERR] = 1'b1;
    end
    // Not-ready alone only updates sense
    if (!devReady) begin
      nxt_sense[`IUSSR_SN_OPER] = 1'b1;
    end
    if (readyRise || ev[`IUSSR_EV_ASYNC]) begin
      nxt_pend[`IUSSR_ST_ALERT] = 1'b1;
      if (readyRise) begin
        nxt_pend[`IUSSR_ST_OPDONE] = 1'b1;
        nxt_sense[`IUSSR_SN_OPER]  = 1'b0;
      end
    end

    // Initial selection
    if (selStart) begin
      nxt_statusValid = 1'b1;
      nxt_retryMark   = 1'b0;
      if (cmdParityBad) begin
        nxt_sense = 8'h00;
        nxt_sense[`IUSSR_SN_PARITY] = 1'b1;
        nxt_statusByte = 8'h00;
        nxt_statusByte[`IUSSR_ST_ERR] = 1'b1;
      end else if (cmdKind == CMD_POLL) begin
        if (noCurrent) begin
          nxt_statusByte = 8'h00;
          nxt_statusByte[`IUSSR_ST_QUAL] = 1'b1;
        end else if (opActive && !endPend) begin
          nxt_statusByte = 8'h00;
          nxt_statusByte[`IUSSR_ST_BUSY] = 1'b1;
        end else begin
          nxt_statusByte = pend_ff;
          nxt_retryMark  = retryPend_ff;
          nxt_pend       = nxt_pend & ~pend_ff;
          nxt_retryPend  = nxt_retryPend & ~retryPend_ff;
        end
      end else if (busyNow) begin
        nxt_statusByte = 8'h00;
        nxt_statusByte[`IUSSR_ST_BUSY] = 1'b1;
        if (shared && opActive) begin
          nxt_statusByte[`IUSSR_ST_QUAL] = 1'b1;
          nxt_pend[`IUSSR_ST_CUFREE]     = 1'b1;
        end
      end else begin
        if (cmdKind == CMD_OTHER) begin
          nxt_sense = 8'h00;
        end
        nxt_statusByte = 8'h00;
        if (cmdIllegal) begin
          nxt_sense[`IUSSR_SN_ILLCMD] = 1'b1;
          nxt_statusByte[`IUSSR_ST_ERR] = 1'b1;
        end else if (!devReady && cmdKind != CMD_QUERY) begin
          nxt_sense[`IUSSR_SN_OPER] = 1'b1;
          nxt_statusByte[`IUSSR_ST_ERR] = 1'b1;
        end else if (cmdKind == CMD_OTHER) begin
          if (ev[`IUSSR_EV_UNUSUAL]) begin
            nxt_statusByte[`IUSSR_ST_UNUSUAL] = 1'b1;
          end else if (cmdImmediate) begin
            nxt_statusByte[`IUSSR_ST_XFER] = 1'b1;
            nxt_state = ST_DEV;
          end else begin
            nxt_state = ST_XFER;
          end
        end else begin
          nxt_statusByte[`IUSSR_ST_XFER]   = 1'b1;
          nxt_statusByte[`IUSSR_ST_OPDONE] = 1'b1;
        end
      end
    end else if (!statusValid && offerPend && statusPollAllowed) begin
      // Stacked status offered when the channel permits
      nxt_statusByte  = pend_ff;
      nxt_statusValid = 1'b1;
      nxt_retryMark   = retryPend_ff;
      // Events of this same cycle stay stacked
      nxt_pend        = nxt_pend & ~pend_ff;
      nxt_retryPend   = nxt_retryPend & ~retryPend_ff;
    end

    if (!shared) begin
      nxt_pend[`IUSSR_ST_CUFREE]       = 1'b0;
      nxt_statusByte[`IUSSR_ST_CUFREE] = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state_ff     <= ST_IDLE;
      pend_ff      <= 8'h00;
      sense_ff     <= 8'h00;
      retryPend_ff <= 1'b0;
      devReadyQ_ff <= 1'b0;
      statusByte   <= 8'h00;
      statusParity <= 1'b1;
      statusValid  <= 1'b0;
      retryMarkTag <= 1'b0;
      senseByte    <= 8'h00;
      ctrl_ff      <= `IUSSR_CTRL_RST;
    end else begin
      state_ff     <= nxt_state;
      pend_ff      <= nxt_pend;
      sense_ff     <= nxt_sense;
      retryPend_ff <= nxt_retryPend;
      devReadyQ_ff <= devReady;
      statusByte   <= nxt_statusByte;
      statusParity <= ~(^nxt_statusByte);
      statusValid  <= nxt_statusValid;
      retryMarkTag <= nxt_retryMark;
      senseByte    <= nxt_sense;
      if (apbWrite && paddr == `IUSSR_CTRL_OFS) begin
        ctrl_ff <= pwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read mux
  always @* begin
    case (paddr)
      `IUSSR_CTRL_OFS:   prdata = {24'h000000, ctrl_ff};
      `IUSSR_STATUS_OFS: prdata = {22'h000000, statusValid, retryMarkTag, statusByte};
      `IUSSR_SENSE_OFS:  prdata = {24'h000000, sense_ff};
      `IUSSR_STATE_OFS:  prdata = {19'h00000, devReady, retryPend_ff, state_ff, pend_ff};
      default:           prdata = 32'h00000000;
    endcase
  end

endmodule // iussr_status_sense

// *** verification/iussr_status_sense_props.sv ***
// Port-level checks of the status and sense block
`timescale 1ns/1ps
module iussr_status_sense_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Command side
  input wire logic       selStart,
  input wire logic [1:0] cmdKind,
  input wire logic       cmdParityBad,
  input wire logic       cmdIllegal,
  input wire logic       cmdImmediate,
  input wire logic       statusAccept,
  // Status and sense
  input wire logic [7:0] statusByte,
  input wire logic       statusParity,
  input wire logic       statusValid,
  input wire logic       retryMarkTag,
  input wire logic [7:0] senseByte
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_parity_odd: assert property (^{statusParity, statusByte})
    else $error("status parity not odd");
  a_clear_accept: assert property (statusValid && statusAccept && !selStart |=> !statusValid)
    else $error("accepted status still presented");
  a_answer_next: assert property (selStart |=> statusValid)
    else $error("no status after selection");
  a_busy_cause: assert property ($rose(statusByte[3]) |-> $past(selStart))
    else $error("busy outside selection");
  a_retry_bits: assert property (retryMarkTag |-> statusValid && statusByte[1] && statusByte[4] && statusByte[6])
    else $error("retry mark without its status bits");
  a_reject_alone: assert property (selStart && cmdIllegal && !cmdParityBad && cmdKind == 2'h0
    |=> statusByte[3] || (statusByte[6] && !statusByte[2] && !statusByte[4] && !statusByte[5]))
    else $error("rejected command with ending bits");
  a_immed_xfer: assert property (selStart && cmdImmediate && !cmdIllegal && !cmdParityBad && cmdKind == 2'h0
    |=> statusByte[3] || statusByte[4])
    else $error("immediate command without transfer complete");
  a_parity_sense: assert property (selStart && cmdParityBad |=> senseByte[2])
    else $error("bad command parity not in sense");
  a_keep_sense: assert property (selStart && cmdKind != 2'h0 && !cmdParityBad |=> $stable(senseByte))
    else $error("sense changed by query, poll or idle");
  c_reject: cover property (selStart && cmdIllegal);
  c_retry: cover property (retryMarkTag);
  c_alert: cover property (statusValid && statusByte[0]);
endmodule // iussr_status_sense_props
bind iussr_status_sense iussr_status_sense_props u_props (.clk, .sys_rst, .selStart, .cmdKind, .cmdParityBad,
  .cmdIllegal, .cmdImmediate, .statusAccept, .statusByte, .statusParity, .statusValid, .retryMarkTag, .senseByte);

// *** verification/iussr_chan_model.sv ***
// Channel-side model: starts selections and accepts status
`timescale 1ns/1ps
module iussr_chan_model (
  // Clock
  input  wire logic       clk,
  // Toward the unit
  output logic            selStart,
  output logic [1:0]      cmdKind,
  output logic            cmdParityBad,
  output logic            cmdIllegal,
  output logic            cmdImmediate,
  output logic            statusAccept,
  output logic            statusPollAllowed
);
  initial begin
    {selStart, cmdKind, cmdImmediate, cmdIllegal, cmdParityBad, statusAccept} = 7'h00;
    statusPollAllowed = 1'h1;
  end
  // One-cycle selection, qualifiers only with it
  task automatic sel(input logic [1:0] kind, input logic imm, input logic ill, input logic par);
    @(posedge clk);
    {selStart, cmdKind, cmdImmediate, cmdIllegal, cmdParityBad} <= {1'h1, kind, imm, ill, par};
    @(posedge clk);
    {selStart, cmdKind, cmdImmediate, cmdIllegal, cmdParityBad} <= 6'h00;
  endtask
  task automatic accept(input int lag);
    repeat (lag) @(posedge clk);
    @(posedge clk);
    statusAccept <= 1'h1;
    @(posedge clk);
    statusAccept <= 1'h0;
  endtask
endmodule // iussr_chan_model

// *** verification/iussr_status_sense_bench.sv ***
// Self-checking bench of the status and sense block
`timescale 1ns/1ps
`include "iussr_regs.vh"
module iussr_status_sense_bench;
  logic        clk = 1'h0;
  logic        sysRst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic        deviceReadyPin = 1'h1;
  wire         pready, pslverr, selStart, cmdParityBad, cmdIllegal, cmdImmediate;
  wire         statusAccept, statusPollAllowed, statusParity, statusValid, retryMarkTag;
  wire [1:0]   cmdKind;
  wire [31:0]  prdata;
  wire [7:0]   statusByte, senseByte;
  int          nErrors = 0;
  int          checksDone = 0;
  always #50 clk = ~clk;
  iussr_chan_model chan (.clk, .selStart, .cmdKind, .cmdParityBad, .cmdIllegal, .cmdImmediate, .statusAccept,
    .statusPollAllowed);
  iussr_status_sense dut (.clk, .sys_rst(sysRst), .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .selStart, .cmdKind, .cmdParityBad, .cmdIllegal, .cmdImmediate, .statusAccept, .statusPollAllowed,
    .deviceReadyPin, .statusByte, .statusParity, .statusValid, .retryMarkTag, .senseByte);
  ////////////////////////////////////////
  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    nErrors++;
    $display("Error at %0t: wait ran out", $time);
    endOfTest();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'h1)
        break;
    end
    if (i == 20)
      hang();
    rd = prdata;
    chk(pslverr, 1'h0);
    {psel, penable} <= 2'h0;
  endtask
  // Wait for presented status, compare, accept
  task automatic st(input logic [7:0] exp, input logic tg = 1'h0, input int lag = 0);
    int i;
    for (i = 0; i < 60 && statusValid !== 1'h1; i++)
      @(posedge clk);
    if (i == 60)
      hang();
    chk({retryMarkTag, statusByte}, {tg, exp});
    chk(statusParity, ~^exp);
    chan.accept(lag);
    #1;
    chk(statusValid, 1'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    chk({statusValid, statusParity, retryMarkTag}, 3'h2);
    sysRst <= 1'h0;
    repeat (12) @(posedge clk);
    apb(1'h0, `IUSSR_STATUS_OFS, 32'h0);
    chk(rd, 32'h0000_0221);
    st(8'h21);
    chan.sel(2'h0, 1'h0, 1'h1, 1'h0);
    st(8'h40);
    chk(senseByte[0], 1'h1);
    chan.sel(2'h2, 1'h0, 1'h0, 1'h0);
    st(8'h00);
    chk(senseByte[0], 1'h1);
    chan.sel(2'h0, 1'h0, 1'h0, 1'h1);
    st(8'h40);
    chk(senseByte, 8'h04);
    chan.sel(2'h0, 1'h1, 1'h0, 1'h0);
    st(8'h10);
    chk(senseByte, 8'h00);
    chan.sel(2'h0, 1'h0, 1'h0, 1'h0);
    st(8'h08, 1'h0, 3);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'h2);
    st(8'h20);
    chan.sel(2'h2, 1'h0, 1'h0, 1'h0);
    st(8'h00);
    chan.sel(2'h0, 1'h0, 1'h0, 1'h0);
    st(8'h00);
    chan.sel(2'h2, 1'h0, 1'h0, 1'h0);
    st(8'h08);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'h1);
    st(8'h10);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'h4);
    st(8'h80);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'h8);
    st(8'h22);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'h4);
    repeat (6) @(posedge clk);
    chk(statusValid, 1'h0);
    apb(1'h0, `IUSSR_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, `IUSSR_CTRL_OFS, 32'h1);
    apb(1'h0, `IUSSR_CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 12'hff0, 32'h0);
    chk(rd, 32'h0);
    chan.sel(2'h0, 1'h1, 1'h0, 1'h0);
    st(8'h10);
    chan.sel(2'h0, 1'h0, 1'h0, 1'h0);
    st(8'h0a);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'h2);
    st(8'h24);
    apb(1'h1, `IUSSR_CTRL_OFS, 32'h2);
    chan.sel(2'h2, 1'h0, 1'h0, 1'h0);
    st(8'h02);
    apb(1'h1, `IUSSR_CTRL_OFS, 32'h0);
    deviceReadyPin <= 1'h0;
    repeat (8) @(posedge clk);
    chk(statusValid, 1'h0);
    deviceReadyPin <= 1'h1;
    st(8'h21);
    chan.sel(2'h0, 1'h0, 1'h0, 1'h0);
    st(8'h00);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'h10);
    st(8'h52, 1'h1);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'he0);
    st(8'h40);
    chk(senseByte, 8'h38);
    apb(1'h1, `IUSSR_EVENT_OFS, 32'h2);
    st(8'h20);
    chan.sel(2'h1, 1'h0, 1'h0, 1'h0);
    st(8'h30);
    chk(senseByte, 8'h38);
    chan.sel(2'h3, 1'h0, 1'h0, 1'h0);
    st(8'h30);
    chk(senseByte, 8'h38);
    endOfTest();
  end
endmodule // iussr_status_sense_bench
